// *** rtl/pwm_forced_output_stop.sv ***
// Our own choices: the APB register port and the address map.
`default_nettype none
module pwm_forced_output_stop
	import pwm_stop_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic overcurrentComparator,
	input wire logic overvoltageStopInput,
	input wire logic restartInput,
	output logic pwmOutPin,
	output logic pwmOutPinOe
);

	logic timerReset_ff;
	logic clkGate_ff;
	logic [2:0] presc_ff;
	logic irqFlag_ff;
	logic irqMask_ff;
	logic countEn_ff;
	logic clkSel_ff;
	stop_ctl_t stopCtl_ff;
	io_ctl_t ioCtl_ff;
	logic [CNT_W-1:0] period_ff;
	logic [CNT_W-1:0] duty_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [4:0] div_ff;
	logic fn1_ff;
	logic fn1Pend_ff;
	logic fn2_ff;
	logic fn2Armed_ff;
	logic [2:0] inS1_ff;
	logic [2:0] inS2_ff;
	logic [2:0] inS3_ff;

	logic setup;
	logic wr;
	logic addrHit;
	logic [31:0] rdVal;
	logic relWrite;
	logic alive;
	logic run;
	logic [2:0] prescCode;
	logic [4:0] divMask;
	logic tick;
	logic periodStart;
	logic restartHit;
	logic periodEdge;
	logic cmpRise;
	logic cmpHigh;
	logic ovFall;
	logic ovRise;
	logic rstRise;
	logic relOk;
	logic pwmLvl;

	////////////////////////////////////////////////////////////
	// APB slave

	assign setup = psel & ~penable;
	assign wr = psel & penable & pready & pwrite;
	assign relWrite = wr & (paddr == OFF_STOP) & pwdata[7];

	always_comb begin
		rdVal = '0;
		addrHit = 1'b1;
		case (paddr)
			OFF_RST: rdVal[RST_BIT] = timerReset_ff;
			OFF_CLKEN: rdVal[CLKEN_BIT] = clkGate_ff;
			OFF_PRESC: rdVal[2:0] = presc_ff;
			OFF_IRQF: rdVal[IRQ_BIT] = irqFlag_ff;
			OFF_IRQM: rdVal[IRQ_BIT] = irqMask_ff;
			OFF_OPCTL: begin
				rdVal[CE_BIT] = countEn_ff;
				rdVal[CKS_BIT] = clkSel_ff;
			end
			OFF_STOP: rdVal[6:0] = stopCtl_ff[6:0];
			OFF_IOCTL: rdVal[1:0] = ioCtl_ff;
			OFF_PERIOD: rdVal[CNT_W-1:0] = period_ff;
			OFF_DUTY: rdVal[CNT_W-1:0] = duty_ff;
			OFF_STAT: begin
				rdVal[ST_FN1] = fn1_ff;
				rdVal[ST_FN2] = fn2_ff;
				rdVal[ST_PEND] = fn1Pend_ff;
				rdVal[ST_ARMED] = fn2Armed_ff;
				rdVal[ST_PIN] = pwmOutPin;
				rdVal[ST_OE] = pwmOutPinOe;
			end
			OFF_CNT: rdVal[CNT_W-1:0] = cnt_ff;
			default: addrHit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~addrHit;
			if (setup) begin
				prdata <= pwrite ? '0 : rdVal;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			timerReset_ff <= 1'b0;
			clkGate_ff <= 1'b0;
			presc_ff <= 3'h0;
			irqMask_ff <= 1'b1;
			countEn_ff <= 1'b0;
			clkSel_ff <= 1'b0;
			stopCtl_ff <= STOP_RV;
			ioCtl_ff <= IO_RV;
			period_ff <= PERIOD_CYC;
			duty_ff <= DUTY_CYC;
		end else if (wr) begin
			case (paddr)
				OFF_RST: timerReset_ff <= pwdata[RST_BIT];
				OFF_CLKEN: clkGate_ff <= pwdata[CLKEN_BIT];
				OFF_PRESC: presc_ff <= pwdata[2:0];
				OFF_IRQM: irqMask_ff <= pwdata[IRQ_BIT];
				OFF_OPCTL: begin
					countEn_ff <= pwdata[CE_BIT];
					clkSel_ff <= pwdata[CKS_BIT];
				end
				OFF_STOP: stopCtl_ff <= {1'b0, pwdata[6:0]};
				OFF_IOCTL: ioCtl_ff <= pwdata[1:0];
				OFF_PERIOD: period_ff <= pwdata[CNT_W-1:0];
				OFF_DUTY: duty_ff <= pwdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// Period flag, hardware set beats software write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irqFlag_ff <= 1'b0;
		end else if (periodEdge) begin
			irqFlag_ff <= 1'b1;
		end else if (wr && paddr == OFF_IRQF) begin
			irqFlag_ff <= pwdata[IRQ_BIT];
		end
	end

	////////////////////////////////////////////////////////////
	// Pin synchronisers, order {restart, over-voltage, comparator}

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			inS1_ff <= IN_IDLE;
			inS2_ff <= IN_IDLE;
			inS3_ff <= IN_IDLE;
		end else begin
			inS1_ff <= {restartInput, overvoltageStopInput, overcurrentComparator};
			inS2_ff <= inS1_ff;
			inS3_ff <= inS2_ff;
		end
	end

	assign cmpHigh = inS2_ff[0];
	assign cmpRise = inS2_ff[0] & ~inS3_ff[0];
	assign ovFall = ~inS2_ff[1] & inS3_ff[1];
	assign ovRise = inS2_ff[1] & ~inS3_ff[1];
	assign rstRise = inS2_ff[2] & ~inS3_ff[2];

	////////////////////////////////////////////////////////////
	// Prescaler and counter

	assign alive = ~timerReset_ff;
	assign run = alive & clkGate_ff;
	assign prescCode = (presc_ff > PRESC_MAX) ? PRESC_MAX : presc_ff;
	assign divMask = 5'h1F >> (PRESC_MAX - prescCode);
	assign tick = run & ~clkSel_ff & ((div_ff & divMask) == divMask);

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !run) begin
			div_ff <= 5'h00;
		end else begin
			div_ff <= div_ff + 5'h01;
		end
	end

	assign periodStart = tick & countEn_ff & ((cnt_ff == CNT_STOP) | (cnt_ff >= period_ff - 16'h0001));
	assign restartHit = rstRise & stopCtl_ff.restartEn & countEn_ff & run;
	assign periodEdge = periodStart | restartHit;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !alive || !countEn_ff) begin
			cnt_ff <= CNT_STOP;
		end else if (restartHit) begin
			cnt_ff <= '0;
		end else if (periodStart) begin
			cnt_ff <= '0;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////
	// Stop function one

	assign relOk = relWrite & ~(stopCtl_ff.clrMode[0] & cmpHigh);

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !alive) begin
			fn1_ff <= 1'b0;
			fn1Pend_ff <= 1'b0;
		end else if (cmpRise && stopCtl_ff.fn1En) begin
			fn1_ff <= 1'b1;
			fn1Pend_ff <= 1'b0;
		end else if (fn1_ff && relOk && !stopCtl_ff.clrMode[1]) begin
			fn1_ff <= 1'b0;
		end else if (fn1Pend_ff && periodEdge) begin
			fn1_ff <= 1'b0;
			fn1Pend_ff <= 1'b0;
		end else if (fn1_ff && relOk) begin
			fn1Pend_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	// Stop function two

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !alive) begin
			fn2_ff <= 1'b0;
			fn2Armed_ff <= 1'b0;
		end else if (ovFall && stopCtl_ff.fn2En) begin
			fn2_ff <= 1'b1;
			fn2Armed_ff <= 1'b0;
		end else if (fn2_ff && fn2Armed_ff && periodEdge) begin
			fn2_ff <= 1'b0;
			fn2Armed_ff <= 1'b0;
		end else if (fn2_ff && ovRise) begin
			fn2Armed_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	// Output pin

	always_comb begin
		if (countEn_ff && cnt_ff != CNT_STOP) begin
			pwmLvl = (cnt_ff < duty_ff) ? ~ioCtl_ff.activeLow : ioCtl_ff.activeLow;
		end else begin
			pwmLvl = ioCtl_ff.defaultHigh;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pwmOutPin <= 1'b0;
			pwmOutPinOe <= 1'b1;
		end else if (fn1_ff) begin
			pwmOutPinOe <= stopCtl_ff.stopSel[1];
			pwmOutPin <= &stopCtl_ff.stopSel;
		end else if (fn2_ff) begin
			pwmOutPinOe <= 1'b1;
			pwmOutPin <= stopCtl_ff.stopSel[0];
		end else begin
			pwmOutPinOe <= 1'b1;
			pwmOutPin <= pwmLvl;
		end
	end

	////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_fn1Trig;
		cmpRise && stopCtl_ff.fn1En && alive && stopCtl_ff.stopSel == 2'b00;
	endsequence

	sequence s_fn1Float;
		fn1_ff ##1 !pwmOutPinOe;
	endsequence

	sequence s_fn2Trig;
		ovFall && stopCtl_ff.fn2En && alive && !fn1_ff && !cmpRise && stopCtl_ff.stopSel == 2'b00;
	endsequence

	a_fn1_float_pin: assert property (s_fn1Trig |=> s_fn1Float)
		else $error("stop one did not float pin");

	a_fn2_low_pin: assert property (s_fn2Trig |=> fn2_ff ##1 (pwmOutPinOe && !pwmOutPin))
		else $error("stop two did not drive low");

	a_fn2_release: assert property (fn2_ff && fn2Armed_ff && periodEdge && !ovFall && alive |=> !fn2_ff)
		else $error("stop two not released");

	a_fn2_hold: assert property (fn2_ff && !fn2Armed_ff && alive |=> fn2_ff)
		else $error("stop two released early");

	a_rel_ignored: assert property (relWrite && fn1_ff && cmpHigh && stopCtl_ff.clrMode[0] && !fn1Pend_ff && alive
		|=> fn1_ff && !fn1Pend_ff)
		else $error("release taken while comparator high");

	a_pend_clear: assert property (fn1Pend_ff && periodEdge && !cmpRise && alive |=> !fn1_ff)
		else $error("stop one not cleared at period");

	a_cnt_stop: assert property (!countEn_ff |=> cnt_ff == CNT_STOP)
		else $error("stopped counter not FFFF");

	a_period_wrap: assert property (tick && countEn_ff && alive && !restartHit && cnt_ff == period_ff - 16'h0001
		|=> cnt_ff == 16'h0000)
		else $error("counter did not wrap");

	a_presc_div8: assert property (tick && prescCode == 3'h3 && $stable(presc_ff) |=> (!tick)[*7])
		else $error("prescaler spacing wrong");

	a_reset_hold: assert property (timerReset_ff |=> cnt_ff == CNT_STOP && !fn1_ff && !fn2_ff)
		else $error("timer not held in reset");

	a_clk_gate: assert property (!clkGate_ff && countEn_ff && alive |=> $stable(cnt_ff))
		else $error("counter moved while gated");

	a_clk_sel: assert property (clkSel_ff && countEn_ff && alive && !restartHit |=> $stable(cnt_ff))
		else $error("tick with other clock selected");

	a_irq_set: assert property (periodEdge |=> irqFlag_ff)
		else $error("period flag not set");

	a_restart_cnt: assert property (restartHit |=> cnt_ff == 16'h0000)
		else $error("restart did not reload counter");

	a_idle_level: assert property (!countEn_ff && !fn1_ff && !fn2_ff
		|=> pwmOutPin == $past(ioCtl_ff.defaultHigh))
		else $error("idle level wrong");

	a_stop_level: assert property (fn1_ff && stopCtl_ff.stopSel[1]
		|=> pwmOutPinOe && pwmOutPin == $past(stopCtl_ff.stopSel[0]))
		else $error("stop level wrong");

	a_pin_follow: assert property (!fn1_ff && !fn2_ff |=> pwmOutPinOe && pwmOutPin == $past(pwmLvl))
		else $error("pin not following waveform");

endmodule
`default_nettype wire

// *** rtl/pwm_stop_pkg.sv ***
`default_nettype none
package pwm_stop_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam logic [ADDR_W-1:0] OFF_RST = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CLKEN = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PRESC = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQF = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQM = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OPCTL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STOP = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IOCTL = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_DUTY = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CNT = 8'h2C;
	localparam int RST_BIT = 0;
	localparam int CLKEN_BIT = 0;
	localparam int IRQ_BIT = 5;
	localparam int CE_BIT = 7;
	localparam int CKS_BIT = 4;
	localparam int ST_FN1 = 0;
	localparam int ST_FN2 = 1;
	localparam int ST_PEND = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_PIN = 4;
	localparam int ST_OE = 5;
	localparam logic [2:0] PRESC_MAX = 3'h5;
	localparam logic [7:0] STOP_RV = 8'h7C;
	localparam logic [1:0] IO_RV = 2'h0;
	localparam logic [2:0] IN_IDLE = 3'h2;
	localparam logic [CNT_W-1:0] CNT_STOP = 16'hFFFF;
	localparam int SYS_CLK_NS = 5;
	localparam int PERIOD_NS = 20000;
	localparam int DUTY_PCT = 50;
	localparam logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(PERIOD_NS / SYS_CLK_NS);
	localparam logic [CNT_W-1:0] DUTY_CYC = CNT_W'(PERIOD_NS / SYS_CLK_NS * DUTY_PCT / 100);
	typedef struct packed {
		logic relTrig;
		logic restartEn;
		logic fn2En;
		logic fn1En;
		logic [1:0] clrMode;
		logic [1:0] stopSel;
	} stop_ctl_t;
	typedef struct packed {
		logic activeLow;
		logic defaultHigh;
	} io_ctl_t;
endpackage
`default_nettype wire

// *** verification/power_stage_model.sv ***
`default_nettype none
module power_stage_model (
	input wire logic sys_clk,
	input wire logic overCurrent,
	input wire logic overVoltage,
	input wire logic restartReq,
	input wire logic pwmOutPin,
	input wire logic pwmOutPinOe,
	output logic overcurrentComparator,
	output logic overvoltageStopInput,
	output logic restartInput,
	output logic loadLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////
	// Load side of the pin, pulled low while released
	assign loadLevel = pwmOutPinOe ? pwmOutPin : 1'b0;
	// Sense and fault lines move just after an edge
	always @(posedge sys_clk) begin
		overcurrentComparator <= overCurrent;
		overvoltageStopInput <= !overVoltage;
		restartInput <= restartReq;
	end
endmodule
`default_nettype wire

// *** verification/pwm_forced_output_stop_tb.sv ***
`default_nettype none
module pwm_forced_output_stop_tb
	import pwm_stop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pwmOutPin, pwmOutPinOe, loadLevel, cmpOut, ovIn, rsIn;
	logic ocReq = 1'b0;
	logic ovReq = 1'b0;
	logic rsReq = 1'b0;
	int badCount = 0;
	int checks = 0;
	int hi, lo, duty;
	logic [33:0] expQ[$];
	logic [7:0] ra[10] = '{OFF_RST, OFF_CLKEN, OFF_PRESC, OFF_IRQF, OFF_IRQM, OFF_OPCTL, OFF_STOP, OFF_IOCTL,
		OFF_PERIOD, OFF_DUTY};
	logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h20, 32'h0, 32'h7C, 32'h0, 32'(PERIOD_CYC), 32'(DUTY_CYC)};
	always #2.5 sys_clk = ~sys_clk;
	pwm_forced_output_stop pwm_forced_output_stop_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .overcurrentComparator(cmpOut), .overvoltageStopInput(ovIn), .restartInput(rsIn),
		.pwmOutPin(pwmOutPin), .pwmOutPinOe(pwmOutPinOe));
	power_stage_model power_stage_model_i (.sys_clk(sys_clk), .overCurrent(ocReq), .overVoltage(ovReq),
		.restartReq(rsReq), .pwmOutPin(pwmOutPin), .pwmOutPinOe(pwmOutPinOe), .overcurrentComparator(cmpOut),
		.overvoltageStopInput(ovIn), .restartInput(rsIn), .loadLevel(loadLevel));
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (badCount == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		badCount++;
		$display("unexpected %0t %s", $time, m);
	endtask
	task automatic cmpPin(input logic got, input logic e, input string m);
		checks++;
		if (got !== e) fail(m);
	endtask
	task automatic cmpInt(input int got, input int e, input string m);
		checks++;
		if (got != e) fail(m);
	endtask
	task automatic cmpBus(input logic [33:0] e);
		checks++;
		if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0])) fail("bus answer");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er, input logic [31:0] e);
		int n;
		expQ.push_back({w, er, e});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail("bus hang");
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 1'b0, e);
	endtask
	always @(posedge sys_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (expQ.size() == 0) fail("answer without request");
			else cmpBus(expQ.pop_front());
		end
	end
	task automatic waitLevel(input logic v, output int n);
		n = 0;
		while (pwmOutPin !== v && n < 70000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 70000) begin
			fail("pin stuck");
			final_report();
		end
	endtask
	task automatic measure();
		int n;
		waitLevel(1'b0, n);
		waitLevel(1'b1, n);
		waitLevel(1'b0, hi);
		waitLevel(1'b1, lo);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge sys_clk);
		fail("timeout");
		final_report();
	end
	initial begin
		void'($urandom(32'h582F));
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		cmpPin(pwmOutPinOe, 1'b1, "oe after reset");
		cmpPin(pwmOutPin, 1'b0, "idle level");
		for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
		rd(OFF_CNT, 32'hFFFF);
		apb(1'b0, 8'h30, 32'h0, 1'b1, 32'h0);
		wr(OFF_CLKEN, 32'h1);
		wr(OFF_OPCTL, 32'h80);
		measure();
		cmpInt(hi, int'(DUTY_CYC), "high time");
		cmpInt(lo, int'(PERIOD_CYC - DUTY_CYC), "low time");
		rd(OFF_IRQF, 32'h20);
		wr(OFF_CLKEN, 32'h0);
		wr(OFF_IRQF, 32'h0);
		repeat (4100) @(posedge sys_clk);
		rd(OFF_IRQF, 32'h0);
		wr(OFF_CLKEN, 32'h1);
		wr(OFF_RST, 32'h1);
		rd(OFF_CNT, 32'hFFFF);
		wr(OFF_RST, 32'h0);
		wr(OFF_PERIOD, 32'h40);
		duty = int'($urandom_range(63, 1));
		wr(OFF_DUTY, 32'(duty));
		for (int c = 0; c < 6; c++) begin
			wr(OFF_PRESC, 32'(c));
			measure();
			cmpInt(hi, duty << c, "scaled high");
			cmpInt(lo, (64 - duty) << c, "scaled low");
		end
		wr(OFF_IOCTL, 32'h2);
		measure();
		cmpInt(hi, (64 - duty) << 5, "active low");
		wr(OFF_OPCTL, 32'h0);
		wr(OFF_IOCTL, 32'h1);
		repeat (4) @(posedge sys_clk);
		cmpPin(pwmOutPin, 1'b1, "default high");
		wr(OFF_OPCTL, 32'h90);
		repeat (100) @(posedge sys_clk);
		rd(OFF_CNT, 32'hFFFF);
		wr(OFF_IOCTL, 32'h0);
		wr(OFF_OPCTL, 32'h80);
		ocReq <= 1'b1;
		repeat (8) @(posedge sys_clk);
		cmpPin(pwmOutPinOe, 1'b0, "stop one float");
		wr(OFF_STOP, 32'hFC);
		repeat (2200) @(posedge sys_clk);
		cmpPin(pwmOutPinOe, 1'b0, "early release");
		ocReq <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wr(OFF_STOP, 32'hFC);
		cmpPin(pwmOutPinOe, 1'b0, "release before period");
		repeat (2200) @(posedge sys_clk);
		cmpPin(pwmOutPinOe, 1'b1, "release at period");
		wr(OFF_DUTY, 32'h0);
		wr(OFF_STOP, 32'h7F);
		ocReq <= 1'b1;
		repeat (8) @(posedge sys_clk);
		cmpPin(loadLevel, 1'b1, "stop one high");
		ocReq <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wr(OFF_STOP, 32'hFC);
		wr(OFF_DUTY, 32'h40);
		repeat (2200) @(posedge sys_clk);
		ovReq <= 1'b1;
		repeat (8) @(posedge sys_clk);
		cmpPin(loadLevel, 1'b0, "stop two low");
		cmpPin(pwmOutPinOe, 1'b1, "stop two driven");
		ovReq <= 1'b0;
		repeat (8) @(posedge sys_clk);
		cmpPin(pwmOutPin, 1'b0, "stop two held");
		repeat (4200) @(posedge sys_clk);
		cmpPin(pwmOutPin, 1'b1, "stop two ended");
		wr(OFF_IRQF, 32'h0);
		rsReq <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rsReq <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(OFF_IRQF, 32'h20);
		final_report();
	end
endmodule
`default_nettype wire
